// ---- tb/tb_type_f_tx_edge_shaping_cfg.sv ----
`timescale 1ns/1ps
module tb_type_f_tx_edge_shaping_cfg;
	import edge_shaping_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic carrier_tick, fall_start, rise_start, edge_double, mod_exp;
	logic [4:0] edge_count;
	logic [7:0] v, amp, len, sty;
	edge_decode_t fall_decode, rise_decode;
	edge_seq_t edge_seq;
	int n_errors, checks_done, seed, c, k;

	// Bus ready loops back from the only slave
	type_f_tx_edge_shaping_cfg dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.carrier_tick(carrier_tick), .fall_start(fall_start), .rise_start(rise_start),
		.fall_decode(fall_decode), .rise_decode(rise_decode), .edge_double(edge_double),
		.edge_count(edge_count), .edge_seq(edge_seq));

	// Clock, 40 ns period
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	task automatic close_out;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Carrier ticks one edge takes: states times one or two
	function automatic int exp_ticks(input logic [7:0] l);
		return int'(l[4:0]) * (l[7] ? 2 : 1);
	endfunction

	// Reserved flag of one edge: unused style code or table index above three
	function automatic logic rsv_exp(input logic [3:0] s, input logic [2:0] f);
		return s == 4'h0 || s > 4'h6 || (s >= 4'h4 && f[2]);
	endfunction

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Waits for hready at a rising edge, bounded
	task automatic wait_rdy;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 20);
		if (hreadyout !== 1'b1) begin
			n_errors++;
			close_out();
		end
	endtask

	// One single-word transfer; read data lands in rd
	task automatic ahb(input logic [5:0] idx, input logic w, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, idx, 2'h0};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask

	// Expected decode of one edge from its style code and config field
	task automatic chk_dec(input edge_decode_t d, input logic [3:0] s, input logic [2:0] f);
		logic fwe, lute;
		fwe = s >= 4'h1 && s <= 4'h3;
		lute = s >= 4'h4 && s <= 4'h6;
		chk("fw", d.fw, fwe);
		chk("lut", d.lut, lute);
		if (fwe) begin
			chk("ramps", d.ramps, s[1:0]);
			chk("time_const", d.time_const, f);
		end
		if (lute) begin
			chk("lut_idx", d.lut_idx, f[1:0]);
			chk("idx_rsv", d.reserved_value, f[2]);
			chk("pa_adapt", d.pa_adapt, s != 4'h4);
			chk("correction", d.correction, s == 4'h5);
		end
		if (!fwe && !lute)
			chk("code_rsv", d.reserved_value, 1'b1);
	endtask

	// Starts one edge and counts carrier ticks until it ends
	task automatic run_edge(input logic fall);
		int n;
		logic [31:0] st_exp;
		@(posedge hclk);
		fall_start <= fall;
		rise_start <= !fall;
		@(posedge hclk);
		fall_start <= 1'b0;
		rise_start <= 1'b0;
		@(posedge hclk);
		#1;
		chk("busy", edge_seq.busy, len[4:0] != 5'h00);
		if (len[4:0] != 5'h00) begin
			chk("falling", edge_seq.falling, fall);
			mod_exp = fall;
		end
		n = 0;
		while (edge_seq.busy === 1'b1 && n < 80) begin
			@(posedge hclk);
			carrier_tick <= 1'b1;
			@(posedge hclk);
			carrier_tick <= 1'b0;
			n++;
			#1;
		end
		if (len[4:0] != 5'h00) begin
			chk("ticks", n, exp_ticks(len));
			chk("state_idx", edge_seq.state_idx, len[4:0] - 5'h01);
			ahb(IDX_STATUS, 1'b0, 32'h0);
			st_exp = {19'h0, len[4:0] - 5'h01, 3'h0, fall, fall, 1'b0,
				rsv_exp(sty[7:4], v[6:4]), rsv_exp(sty[3:0], v[2:0])};
			chk("status", rd, st_exp);
		end
		chk("modulating", edge_seq.modulating, mod_exp);
		chk("amplitude", edge_seq.amplitude, mod_exp ? amp : 8'hFF);
	endtask

	// Watchdog
	initial begin
		repeat (100000) @(posedge hclk);
		n_errors++;
		close_out();
	end

	// Main sequence
	initial begin
		seed = 69718;
		n_errors = 0;
		checks_done = 0;
		{hresetn, hsel, hwrite, carrier_tick, fall_start, rise_start, mod_exp} = 7'h00;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		amp = 8'h00;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(IDX_STYLE_SELECT, 1'b0, 32'h0);
		chk("style_rst", rd, RST_STYLE_SELECT);
		ahb(IDX_EDGE_LENGTH, 1'b0, 32'h0);
		chk("length_rst", rd, RST_EDGE_LENGTH);
		ahb(6'h10, 1'b1, 32'hFF);
		ahb(6'h10, 1'b0, 32'h0);
		chk("unmapped", rd, 32'h0);
		chk("hresp", hresp, 1'b0);
		// Every style code on both nibbles, random config field
		for (c = 0; c < 16; c++) begin
			v = 8'($random(seed));
			sty = {c[3:0], 4'hF - c[3:0]};
			ahb(IDX_STYLE_SELECT, 1'b1, {24'h0, sty});
			ahb(IDX_SHAPE_CONFIG, 1'b1, {24'h0, v});
			#1;
			chk_dec(fall_decode, c[3:0], v[6:4]);
			chk_dec(rise_decode, 4'hF - c[3:0], v[2:0]);
			ahb(IDX_SHAPE_CONFIG, 1'b0, 32'h0);
			chk("cfg_read", rd, {24'h0, v});
		end
		// Edge lengths: zero, longest doubled, shortest, then random
		for (k = 0; k < 6; k++) begin
			amp = 8'($random(seed));
			len = (k == 0) ? 8'h00 : (k == 1) ? 8'h9F : (k == 2) ? 8'h01 : 8'($random(seed)) & 8'h87;
			sty = 8'($random(seed));
			ahb(IDX_STYLE_SELECT, 1'b1, {24'h0, sty});
			ahb(IDX_RESIDUAL_AMPL, 1'b1, {24'h0, amp});
			ahb(IDX_EDGE_LENGTH, 1'b1, {24'h0, len});
			#1;
			chk("edge_double", edge_double, len[7]);
			chk("edge_count", edge_count, len[4:0]);
			run_edge(1'b1);
			run_edge(1'b0);
		end
		// Reset after a falling edge has ended, while the carrier is modulated
		len = 8'h02;
		ahb(IDX_EDGE_LENGTH, 1'b1, {24'h0, len});
		run_edge(1'b1);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		#1;
		chk("mod_rst", edge_seq.modulating, 1'b0);
		chk("ampl_rst", edge_seq.amplitude, AMPL_FULL);
		@(posedge hclk);
		hresetn <= 1'b1;
		ahb(IDX_SHAPE_CONFIG, 1'b0, 32'h0);
		chk("cfg_rst", rd, RST_SHAPE_CONFIG);
		ahb(IDX_RESIDUAL_AMPL, 1'b0, 32'h0);
		chk("resid_rst", rd, RST_RESIDUAL_AMPL);
		ahb(IDX_EDGE_LENGTH, 1'b0, 32'h0);
		chk("len_rst", rd, RST_EDGE_LENGTH);
		close_out();
	end
endmodule // tb_type_f_tx_edge_shaping_cfg

// ---- verilog/edge_shaping_pkg.sv ----
package edge_shaping_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_STYLE_SELECT = 6'h35;
	localparam logic [5:0] IDX_SHAPE_CONFIG = 6'h36;
	localparam logic [5:0] IDX_EDGE_LENGTH = 6'h37;
	localparam logic [5:0] IDX_RESIDUAL_AMPL = 6'h38;
	localparam logic [5:0] IDX_STATUS = 6'h3F;

	// Reset values
	localparam logic [7:0] RST_STYLE_SELECT = 8'h11;
	localparam logic [7:0] RST_SHAPE_CONFIG = 8'h00;
	localparam logic [7:0] RST_EDGE_LENGTH = 8'h01;
	localparam logic [7:0] RST_RESIDUAL_AMPL = 8'h00;
	localparam logic [7:0] AMPL_FULL = 8'hFF;

	// Field positions
	localparam int FALL_STYLE_LSB = 4;
	localparam int RISE_STYLE_LSB = 0;
	localparam int FALL_CFG_LSB = 4;
	localparam int RISE_CFG_LSB = 0;
	localparam int LEN_DOUBLE_BIT = 7;
	localparam int LEN_COUNT_MSB = 4;

	// Status register bit positions
	localparam int ST_RISE_RSV = 0;
	localparam int ST_FALL_RSV = 1;
	localparam int ST_BUSY = 2;
	localparam int ST_FALLING = 3;
	localparam int ST_MODULATING = 4;
	localparam int ST_CNT_LSB = 8;

	// Style codes
	localparam logic [3:0] STYLE_FW_ONE = 4'h1;
	localparam logic [3:0] STYLE_FW_THREE = 4'h3;
	localparam logic [3:0] STYLE_LUT_PLAIN = 4'h4;
	localparam logic [3:0] STYLE_LUT_CORR = 4'h5;
	localparam logic [3:0] STYLE_LUT_NOCORR = 4'h6;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// Decoded shaping choice for one edge
	typedef struct packed {
		logic fw;
		logic lut;
		logic reserved_value;
		logic [1:0] ramps;
		logic [2:0] time_const;
		logic [1:0] lut_idx;
		logic pa_adapt;
		logic correction;
	} edge_decode_t;

	// Edge sequencer view for the waveform generator
	typedef struct packed {
		logic busy;
		logic falling;
		logic [4:0] state_idx;
		logic modulating;
		logic [7:0] amplitude;
	} edge_seq_t;

endpackage

// ---- verilog/type_f_tx_edge_shaping_cfg.sv ----
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module type_f_tx_edge_shaping_cfg (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic carrier_tick,
	input wire logic fall_start,
	input wire logic rise_start,
	output edge_shaping_pkg::edge_decode_t fall_decode,
	output edge_shaping_pkg::edge_decode_t rise_decode,
	output logic edge_double,
	output logic [4:0] edge_count,
	output edge_shaping_pkg::edge_seq_t edge_seq
);
	import edge_shaping_pkg::*;

	// Whole state of the block
	typedef struct packed {
		logic [7:0] style_sel;
		logic [7:0] shape_cfg;
		logic [7:0] edge_len;
		logic [7:0] residual;
		logic wr_pend;
		logic [5:0] wr_idx;
		logic [31:0] rdata;
		logic busy;
		logic falling;
		logic half;
		logic [4:0] state_cnt;
		logic modulating;
	} state_t;

	state_t st_q;
	state_t st_d;
	edge_decode_t dec [2];
	logic [3:0] style_code [2];
	logic [2:0] cfg_field [2];
	logic addr_hit;
	logic [5:0] addr_idx;
	logic [4:0] last_state;

	// Select which nibble and field feed each edge; index 0 rising, 1 falling
	assign style_code[1] = st_q.style_sel[FALL_STYLE_LSB +: 4];
	assign style_code[0] = st_q.style_sel[RISE_STYLE_LSB +: 4];
	assign cfg_field[1] = st_q.shape_cfg[FALL_CFG_LSB +: 3];
	assign cfg_field[0] = st_q.shape_cfg[RISE_CFG_LSB +: 3];

	// Same style decode for both edges
	for (genvar e = 0; e < 2; e++) begin : g_decode
		always_comb begin
			dec[e] = '0;
			if (style_code[e] >= STYLE_FW_ONE && style_code[e] <= STYLE_FW_THREE) begin
				dec[e].fw = 1'b1;
				dec[e].ramps = style_code[e][1:0];
				dec[e].time_const = cfg_field[e];
			end else if (style_code[e] >= STYLE_LUT_PLAIN &&
				style_code[e] <= STYLE_LUT_NOCORR) begin
				dec[e].lut = 1'b1;
				dec[e].lut_idx = cfg_field[e][1:0];
				dec[e].reserved_value = cfg_field[e][2]; // Table index above 3
				dec[e].pa_adapt = (style_code[e] != STYLE_LUT_PLAIN);
				dec[e].correction = (style_code[e] == STYLE_LUT_CORR);
			end else begin
				dec[e].reserved_value = 1'b1; // Unused style code
			end
		end
	end

	// Decoded outputs
	assign fall_decode = dec[1];
	assign rise_decode = dec[0];
	assign edge_double = st_q.edge_len[LEN_DOUBLE_BIT];
	assign edge_count = st_q.edge_len[LEN_COUNT_MSB:0];
	assign last_state = edge_count - 5'h01;

	// Sequencer view, amplitude is residual byte while modulated
	assign edge_seq.busy = st_q.busy;
	assign edge_seq.falling = st_q.falling;
	assign edge_seq.state_idx = st_q.state_cnt;
	assign edge_seq.modulating = st_q.modulating;
	assign edge_seq.amplitude = st_q.modulating ? st_q.residual : AMPL_FULL;

	// Bus answer: zero wait, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_q.rdata;

	// Address decode, upper bits must be zero
	assign addr_hit = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
	assign addr_idx = haddr[7:2];

	// Next state
	always_comb begin
		st_d = st_q;
		// Data phase of a pending write
		if (st_q.wr_pend) begin
			if (st_q.wr_idx == IDX_STYLE_SELECT) begin
				st_d.style_sel = hwdata[7:0];
			end else if (st_q.wr_idx == IDX_SHAPE_CONFIG) begin
				st_d.shape_cfg = hwdata[7:0];
			end else if (st_q.wr_idx == IDX_EDGE_LENGTH) begin
				st_d.edge_len = hwdata[7:0];
			end else if (st_q.wr_idx == IDX_RESIDUAL_AMPL) begin
				st_d.residual = hwdata[7:0];
			end
		end
		st_d.wr_pend = 1'b0;
		// Address phase: latch write target or read data
		if (hsel && htrans == HTRANS_NONSEQ && hready) begin
			st_d.wr_pend = hwrite && addr_hit;
			st_d.wr_idx = addr_idx;
			st_d.rdata = '0;
			if (!hwrite && addr_hit) begin
				if (addr_idx == IDX_STYLE_SELECT) begin
					st_d.rdata[7:0] = st_d.style_sel;
				end else if (addr_idx == IDX_SHAPE_CONFIG) begin
					st_d.rdata[7:0] = st_d.shape_cfg;
				end else if (addr_idx == IDX_EDGE_LENGTH) begin
					st_d.rdata[7:0] = st_d.edge_len;
				end else if (addr_idx == IDX_RESIDUAL_AMPL) begin
					st_d.rdata[7:0] = st_d.residual;
				end else if (addr_idx == IDX_STATUS) begin
					st_d.rdata[ST_RISE_RSV] = dec[0].reserved_value;
					st_d.rdata[ST_FALL_RSV] = dec[1].reserved_value;
					st_d.rdata[ST_BUSY] = st_q.busy;
					st_d.rdata[ST_FALLING] = st_q.falling;
					st_d.rdata[ST_MODULATING] = st_q.modulating;
					st_d.rdata[ST_CNT_LSB +: 5] = st_q.state_cnt;
				end
			end
		end
		// Edge sequencer: counts transition states in carrier cycles
		if (!st_q.busy) begin
			if ((fall_start || rise_start) && edge_count != 5'h00) begin
				st_d.busy = 1'b1;
				st_d.falling = fall_start;
				st_d.state_cnt = 5'h00;
				st_d.half = 1'b0;
			end
		end else if (carrier_tick) begin
			if (edge_double && !st_q.half) begin
				st_d.half = 1'b1;
			end else begin
				st_d.half = 1'b0;
				if (st_q.state_cnt == last_state) begin
					st_d.busy = 1'b0;
					st_d.modulating = st_q.falling;
				end else begin
					st_d.state_cnt = st_q.state_cnt + 5'h01;
				end
			end
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= '0;
			st_q.style_sel <= RST_STYLE_SELECT;
			st_q.shape_cfg <= RST_SHAPE_CONFIG;
			st_q.edge_len <= RST_EDGE_LENGTH;
			st_q.residual <= RST_RESIDUAL_AMPL;
		end else begin
			st_q <= st_d;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Style nibble and config field checks
	fall_style_a: assert property (fall_decode.lut ==
		(st_q.style_sel[7:4] >= 4'h4 && st_q.style_sel[7:4] <= 4'h6))
		else $error("falling style not from upper nibble");
	rise_style_a: assert property (rise_decode.fw ==
		(st_q.style_sel[3:0] >= 4'h1 && st_q.style_sel[3:0] <= 4'h3))
		else $error("rising style not from lower nibble");
	fw_ramps_a: assert property (fall_decode.fw |->
		fall_decode.ramps == st_q.style_sel[5:4] && !fall_decode.lut)
		else $error("ramp count wrong");
	lut_plain_a: assert property (st_q.style_sel[3:0] == 4'h4 |->
		rise_decode.lut && !rise_decode.pa_adapt && !rise_decode.correction)
		else $error("plain table style wrong");
	lut_corr_a: assert property (st_q.style_sel[7:4] == 4'h5 |->
		fall_decode.lut && fall_decode.pa_adapt && fall_decode.correction)
		else $error("corrected table style wrong");
	lut_nocorr_a: assert property (st_q.style_sel[3:0] == 4'h6 |->
		rise_decode.pa_adapt && !rise_decode.correction)
		else $error("uncorrected table style wrong");
	fall_tc_a: assert property (fall_decode.fw |->
		fall_decode.time_const == st_q.shape_cfg[6:4])
		else $error("falling time constant wrong");
	fall_lut_a: assert property (fall_decode.lut |->
		fall_decode.lut_idx == st_q.shape_cfg[5:4] &&
		fall_decode.reserved_value == st_q.shape_cfg[6])
		else $error("falling table index wrong");
	rise_tc_a: assert property (rise_decode.fw |->
		rise_decode.time_const == st_q.shape_cfg[2:0])
		else $error("rising time constant wrong");
	rise_lut_a: assert property (rise_decode.lut |->
		rise_decode.lut_idx == st_q.shape_cfg[1:0])
		else $error("rising table index wrong");

	// One carrier cycle per state when not doubled
	sequence tick_single_s;
		edge_seq.busy && carrier_tick && !edge_double && edge_seq.state_idx != last_state;
	endsequence
	single_cycle_a: assert property (tick_single_s |=>
		edge_seq.state_idx == $past(edge_seq.state_idx) + 5'h01)
		else $error("state did not advance after one carrier cycle");

	// Two carrier cycles per state when doubled
	sequence first_half_s;
		edge_seq.busy && carrier_tick && edge_double && !st_q.half;
	endsequence
	double_cycle_a: assert property (first_half_s |=>
		$stable(edge_seq.state_idx) && edge_seq.busy)
		else $error("state advanced on first of two carrier cycles");

	// Edge ends on the last counted state
	sequence last_tick_s;
		edge_seq.busy && carrier_tick && (!edge_double || st_q.half) &&
			edge_seq.state_idx == last_state;
	endsequence
	state_count_a: assert property (last_tick_s |=> !edge_seq.busy)
		else $error("edge did not end at state count");

	// Amplitude follows residual level while modulated
	residual_ampl_a: assert property (edge_seq.modulating |->
		edge_seq.amplitude == st_q.residual)
		else $error("modulated amplitude not residual level");

	// Style select takes the written byte one edge after its data phase
	style_write_a: assert property (st_q.wr_pend &&
		st_q.wr_idx == IDX_STYLE_SELECT |=> st_q.style_sel == $past(hwdata[7:0]))
		else $error("style select write lost");

	// Shape config takes the written byte one edge after its data phase
	shape_write_a: assert property (st_q.wr_pend &&
		st_q.wr_idx == IDX_SHAPE_CONFIG |=> st_q.shape_cfg == $past(hwdata[7:0]))
		else $error("shape config write lost");

	// Edge length takes the written byte one edge after its data phase
	length_write_a: assert property (st_q.wr_pend &&
		st_q.wr_idx == IDX_EDGE_LENGTH |=> st_q.edge_len == $past(hwdata[7:0]))
		else $error("edge length write lost");

	// Residual level takes the written byte one edge after its data phase
	residual_write_a: assert property (st_q.wr_pend &&
		st_q.wr_idx == IDX_RESIDUAL_AMPL |=> st_q.residual == $past(hwdata[7:0]))
		else $error("residual level write lost");

	// Edge length only changes through a bus write
	length_hold_a: assert property (!(st_q.wr_pend &&
		st_q.wr_idx == IDX_EDGE_LENGTH) |=> $stable(st_q.edge_len))
		else $error("edge length changed without a write");

	// Residual level only changes through a bus write
	residual_hold_a: assert property (!(st_q.wr_pend &&
		st_q.wr_idx == IDX_RESIDUAL_AMPL) |=> $stable(st_q.residual))
		else $error("residual level changed without a write");

	// Unused falling style codes are flagged and select no shaping
	fall_code_rsv_a: assert property (st_q.style_sel[7:4] == 4'h0 ||
		st_q.style_sel[7:4] > 4'h6 |-> fall_decode.reserved_value && !fall_decode.fw)
		else $error("unused falling style code not flagged");

	// Unused rising style codes are flagged and select no shaping
	rise_code_rsv_a: assert property (st_q.style_sel[3:0] == 4'h0 ||
		st_q.style_sel[3:0] > 4'h6 |-> rise_decode.reserved_value && !rise_decode.lut)
		else $error("unused rising style code not flagged");

	// Rising firmware shaping uses as many ramps as its code
	rise_ramps_a: assert property (rise_decode.fw |->
		rise_decode.ramps == st_q.style_sel[1:0] && !rise_decode.lut)
		else $error("rising ramp count wrong");

	// Plain table style on the falling edge has no supply adaptation
	fall_plain_a: assert property (st_q.style_sel[7:4] == 4'h4 |->
		fall_decode.lut && !fall_decode.pa_adapt && !fall_decode.correction)
		else $error("falling plain table style wrong");

	// Corrected table style on the rising edge adapts and corrects
	rise_corr_a: assert property (st_q.style_sel[3:0] == 4'h5 |->
		rise_decode.lut && rise_decode.pa_adapt && rise_decode.correction)
		else $error("rising corrected table style wrong");

	// Rising table index above three is flagged
	rise_idx_rsv_a: assert property (rise_decode.lut |->
		rise_decode.reserved_value == st_q.shape_cfg[2])
		else $error("rising table index range not flagged");

	// An idle start request with a nonzero count opens the edge at state zero
	sequence start_s;
		!edge_seq.busy && (fall_start || rise_start) && edge_count != 5'h00;
	endsequence
	edge_start_a: assert property (start_s |=> edge_seq.busy &&
		edge_seq.state_idx == 5'h00 && edge_seq.falling == $past(fall_start))
		else $error("edge did not start at state zero");

	// A zero state count never opens an edge
	zero_count_a: assert property (!edge_seq.busy && edge_count == 5'h00 |=>
		!edge_seq.busy)
		else $error("edge started with zero state count");

	// Without a carrier tick a running edge holds its state and direction
	no_tick_a: assert property (edge_seq.busy && !carrier_tick |=>
		edge_seq.busy && $stable(edge_seq.state_idx) && $stable(edge_seq.falling))
		else $error("edge moved without a carrier tick");

	// Second carrier cycle of a doubled state moves on
	sequence second_half_s;
		edge_seq.busy && carrier_tick && edge_double && st_q.half &&
			edge_seq.state_idx != last_state;
	endsequence
	double_advance_a: assert property (second_half_s |=>
		edge_seq.state_idx == $past(edge_seq.state_idx) + 5'h01 && !st_q.half)
		else $error("doubled state did not advance on second carrier cycle");

	// A finished falling edge leaves the carrier modulated, a rising one restores it
	end_mod_a: assert property (last_tick_s |=>
		edge_seq.modulating == $past(edge_seq.falling))
		else $error("modulation state wrong after edge");

	// Unmodulated carrier stands at full amplitude
	full_ampl_a: assert property (!edge_seq.modulating |->
		edge_seq.amplitude == AMPL_FULL)
		else $error("unmodulated amplitude not full carrier");

	// Modulation state only changes when an edge ends
	mod_hold_a: assert property (!edge_seq.busy |=>
		$stable(edge_seq.modulating))
		else $error("modulation changed while idle");

	// Status read reports the sequencer state of its address phase
	status_read_a: assert property (hsel && htrans == HTRANS_NONSEQ && hready &&
		!hwrite && addr_hit && addr_idx == IDX_STATUS |=>
		hrdata[ST_CNT_LSB +: 5] == $past(edge_seq.state_idx) &&
		hrdata[ST_BUSY] == $past(edge_seq.busy))
		else $error("status read wrong");

endmodule // type_f_tx_edge_shaping_cfg
